// File: hdc_pkg.sv
// Shared constants and carriers for the hub descriptor configuration bank
package hdc_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses on the configuration port)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_HC_CURRENT   = 8'h0F;
	localparam logic [7:0] OFF_POWER_ON     = 8'h10;
	localparam logic [7:0] OFF_LANG_UPPER   = 8'h11;
	localparam logic [7:0] OFF_LANG_LOWER   = 8'h12;
	localparam logic [7:0] OFF_MAKER_LEN    = 8'h13;
	localparam logic [7:0] OFF_PRODUCT_LEN  = 8'h14;
	localparam logic [7:0] OFF_SERIAL_LEN   = 8'h15;
	localparam logic [7:0] OFF_MAKER_TEXT   = 8'h16;
	localparam logic [7:0] OFF_PRODUCT_TEXT = 8'h54;
	localparam logic [7:0] OFF_SERIAL_TEXT  = 8'h92;
	localparam logic [7:0] OFF_TEXT_LAST    = 8'hCF;

	// ----------------------------------------------------------------
	// Reset values, limits and scales
	// ----------------------------------------------------------------
	localparam logic [7:0] HC_CURRENT_RESET = 8'h32;
	localparam logic [7:0] REG_RESET        = 8'h00;
	localparam logic [7:0] MAX_TEXT_CHARS   = 8'h1F;
	localparam int unsigned CURRENT_STEP_MA = 2;
	localparam int unsigned TEXT_BYTES      = int'(OFF_TEXT_LAST) - int'(OFF_MAKER_TEXT) + 1;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_KHZ            = 125000;
	localparam int unsigned POWER_STEP_MS      = 2;
	localparam int unsigned POWER_STEP_CYCLES  = POWER_STEP_MS * CLK_KHZ;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {HDC_SEL_MAKER, HDC_SEL_PRODUCT, HDC_SEL_SERIAL} hdc_text_sel_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hdc_cfg_access_t;

	typedef struct packed {
		logic        valid;
		logic        last;
		logic [15:0] data;
	} hdc_text_char_t;

endpackage

// File: hdc_config_bank.sv
// Hub descriptor configuration bank: registers, string store and fetch
//
// Notes on behaviour
// - Hub controller current byte counts in 2 mA steps.
// - Hub controller current byte resets to 50, meaning 100 mA.
// - Power-on byte is delay in 2 ms units from port power start.
// - Language id is upper byte in bits 15..8, lower in 7..0.
// - String lengths stay at or below 31; longer writes are refused.
// - Each stored character is one 16-bit UTF-16LE code unit.
// - Character low byte at lower address; characters ascend contiguously.
// - Maker string characters come from bytes 16h to 53h.
// - Product string characters come from bytes 54h to 91h.
// - Serial string characters come from bytes 92h to CFh.
`timescale 1ns/1ps
`default_nettype none

module hdc_config_bank
	import hdc_pkg::*;
#(
	parameter int unsigned STEP_CYCLES = POWER_STEP_CYCLES
)(
	input  wire logic            clk,
	input  wire logic            nrst,
	input  wire hdc_cfg_access_t cfg,
	input  wire logic            text_req,
	input  wire hdc_text_sel_t   text_sel,
	input  wire logic            port_power_start,
	output var  logic [7:0]      cfg_rdata,
	output var  logic            cfg_rvalid,
	output var  logic            cfg_refused,
	output var  logic [8:0]      hub_ctrl_current_ma,
	output var  logic [15:0]     language_id,
	output var  logic            port_power_good,
	output var  hdc_text_char_t  text_out,
	output var  logic            text_done,
	output var  logic            text_busy
);

	localparam int STEP_W = $clog2(STEP_CYCLES + 1);
	localparam logic [7:0] BASE_MAKER   = 8'h00;
	localparam logic [7:0] BASE_PRODUCT = 8'(OFF_PRODUCT_TEXT - OFF_MAKER_TEXT);
	localparam logic [7:0] BASE_SERIAL  = 8'(OFF_SERIAL_TEXT - OFF_MAKER_TEXT);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [7:0] hc_current_reg,  hc_current_next;
	logic [7:0] power_on_reg,    power_on_next;
	logic [7:0] lang_upper_reg,  lang_upper_next;
	logic [7:0] lang_lower_reg,  lang_lower_next;
	logic [7:0] maker_len_reg,   maker_len_next;
	logic [7:0] product_len_reg, product_len_next;
	logic [7:0] serial_len_reg,  serial_len_next;
	logic [7:0] rdata_next;
	logic       refused_next;
	logic       text_hit;
	logic [7:0] text_idx;
	logic [7:0] text_mem [TEXT_BYTES];

	assign text_hit = (cfg.addr >= OFF_MAKER_TEXT) && (cfg.addr <= OFF_TEXT_LAST);
	assign text_idx = cfg.addr - OFF_MAKER_TEXT;

	always_comb
	begin
		hc_current_next  = hc_current_reg;
		power_on_next    = power_on_reg;
		lang_upper_next  = lang_upper_reg;
		lang_lower_next  = lang_lower_reg;
		maker_len_next   = maker_len_reg;
		product_len_next = product_len_reg;
		serial_len_next  = serial_len_reg;
		refused_next     = 1'b0;
		rdata_next       = REG_RESET;
		if (cfg.wr)
		begin
			// Over-long counts would overrun the next string region
			if ((cfg.addr == OFF_MAKER_LEN || cfg.addr == OFF_PRODUCT_LEN ||
				cfg.addr == OFF_SERIAL_LEN) && cfg.wdata > MAX_TEXT_CHARS)
				refused_next = 1'b1;
			else
			begin
				unique case (cfg.addr)
					OFF_HC_CURRENT:  hc_current_next  = cfg.wdata;
					OFF_POWER_ON:    power_on_next    = cfg.wdata;
					OFF_LANG_UPPER:  lang_upper_next  = cfg.wdata;
					OFF_LANG_LOWER:  lang_lower_next  = cfg.wdata;
					OFF_MAKER_LEN:   maker_len_next   = cfg.wdata;
					OFF_PRODUCT_LEN: product_len_next = cfg.wdata;
					OFF_SERIAL_LEN:  serial_len_next  = cfg.wdata;
					default:         ;
				endcase
			end
		end
		if (cfg.rd)
		begin
			unique case (cfg.addr)
				OFF_HC_CURRENT:  rdata_next = hc_current_reg;
				OFF_POWER_ON:    rdata_next = power_on_reg;
				OFF_LANG_UPPER:  rdata_next = lang_upper_reg;
				OFF_LANG_LOWER:  rdata_next = lang_lower_reg;
				OFF_MAKER_LEN:   rdata_next = maker_len_reg;
				OFF_PRODUCT_LEN: rdata_next = product_len_reg;
				OFF_SERIAL_LEN:  rdata_next = serial_len_reg;
				default:         rdata_next = text_hit ? text_mem[text_idx] : REG_RESET;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			hc_current_reg      <= HC_CURRENT_RESET;
			power_on_reg        <= REG_RESET;
			lang_upper_reg      <= REG_RESET;
			lang_lower_reg      <= REG_RESET;
			maker_len_reg       <= REG_RESET;
			product_len_reg     <= REG_RESET;
			serial_len_reg      <= REG_RESET;
			cfg_rdata           <= REG_RESET;
			cfg_rvalid          <= 1'b0;
			cfg_refused         <= 1'b0;
			hub_ctrl_current_ma <= '0;
			language_id         <= '0;
		end
		else
		begin
			hc_current_reg      <= hc_current_next;
			power_on_reg        <= power_on_next;
			lang_upper_reg      <= lang_upper_next;
			lang_lower_reg      <= lang_lower_next;
			maker_len_reg       <= maker_len_next;
			product_len_reg     <= product_len_next;
			serial_len_reg      <= serial_len_next;
			cfg_rdata           <= rdata_next;
			cfg_rvalid          <= cfg.rd;
			cfg_refused         <= refused_next;
			hub_ctrl_current_ma <= 9'(hc_current_reg * CURRENT_STEP_MA);
			language_id         <= {lang_upper_reg, lang_lower_reg};
		end
	end

	// String store is not reset; contents are only valid once loaded
	always_ff @(posedge clk)
	begin
		if (cfg.wr && text_hit)
			text_mem[text_idx] <= cfg.wdata;
	end

	// ----------------------------------------------------------------
	// Port power-on timer
	// ----------------------------------------------------------------
	logic              pwr_run_reg,   pwr_run_next;
	logic [STEP_W-1:0] step_cnt_reg,  step_cnt_next;
	logic [7:0]        steps_left_reg, steps_left_next;
	logic              power_good_next;

	always_comb
	begin
		pwr_run_next    = pwr_run_reg;
		step_cnt_next   = step_cnt_reg;
		steps_left_next = steps_left_reg;
		power_good_next = port_power_good;
		if (port_power_start)
		begin
			pwr_run_next    = 1'b1;
			step_cnt_next   = '0;
			steps_left_next = power_on_reg;
			power_good_next = 1'b0;
		end
		else if (pwr_run_reg)
		begin
			if (steps_left_reg == '0)
			begin
				pwr_run_next    = 1'b0;
				power_good_next = 1'b1;
			end
			else if (step_cnt_reg == STEP_W'(STEP_CYCLES - 1))
			begin
				step_cnt_next   = '0;
				steps_left_next = steps_left_reg - 8'h01;
			end
			else
				step_cnt_next = step_cnt_reg + STEP_W'(1);
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pwr_run_reg     <= 1'b0;
			step_cnt_reg    <= '0;
			steps_left_reg  <= '0;
			port_power_good <= 1'b0;
		end
		else
		begin
			pwr_run_reg     <= pwr_run_next;
			step_cnt_reg    <= step_cnt_next;
			steps_left_reg  <= steps_left_next;
			port_power_good <= power_good_next;
		end
	end

	// ----------------------------------------------------------------
	// String descriptor character fetch
	// ----------------------------------------------------------------
	typedef enum logic {HDC_IDLE, HDC_EMIT} hdc_fetch_state_t;

	hdc_fetch_state_t state_reg, state_next;
	logic [7:0]       idx_reg,   idx_next;
	logic [4:0]       remain_reg, remain_next;
	hdc_text_char_t   char_next;
	logic             done_next;
	logic             busy_next;
	logic [7:0]       sel_len;
	logic [7:0]       sel_base;
	logic             take;
	logic [15:0]      pair_now;

	always_comb
	begin
		unique case (text_sel)
			HDC_SEL_MAKER:   {sel_len, sel_base} = {maker_len_reg, BASE_MAKER};
			HDC_SEL_PRODUCT: {sel_len, sel_base} = {product_len_reg, BASE_PRODUCT};
			HDC_SEL_SERIAL:  {sel_len, sel_base} = {serial_len_reg, BASE_SERIAL};
			default:         {sel_len, sel_base} = {REG_RESET, BASE_MAKER};
		endcase
	end

	assign take     = text_req && (state_reg == HDC_IDLE);
	assign pair_now = {text_mem[idx_reg + 8'h01], text_mem[idx_reg]};

	always_comb
	begin
		state_next  = state_reg;
		idx_next    = idx_reg;
		remain_next = remain_reg;
		char_next   = '0;
		done_next   = 1'b0;
		unique case (state_reg)
			HDC_IDLE:
				if (take)
				begin
					if (sel_len == REG_RESET)
						done_next = 1'b1;
					else
					begin
						state_next  = HDC_EMIT;
						idx_next    = sel_base;
						remain_next = sel_len[4:0];
					end
				end
			HDC_EMIT:
			begin
				char_next.valid = 1'b1;
				char_next.data  = pair_now;
				char_next.last  = (remain_reg == 5'h01);
				idx_next        = idx_reg + 8'h02;
				remain_next     = remain_reg - 5'h01;
				if (remain_reg == 5'h01)
				begin
					state_next = HDC_IDLE;
					done_next  = 1'b1;
				end
			end
		endcase
		busy_next = (state_next == HDC_EMIT);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg  <= HDC_IDLE;
			idx_reg    <= '0;
			remain_reg <= '0;
			text_out   <= '0;
			text_done  <= 1'b0;
			text_busy  <= 1'b0;
		end
		else
		begin
			state_reg  <= state_next;
			idx_reg    <= idx_next;
			remain_reg <= remain_next;
			text_out   <= char_next;
			text_done  <= done_next;
			text_busy  <= busy_next;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [31:0] pwr_elapsed;
	logic [7:0]  pwr_snap;
	logic [5:0]  emitted;
	logic [7:0]  len_snap;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pwr_elapsed <= '0;
			pwr_snap    <= '0;
			emitted     <= '0;
			len_snap    <= '0;
		end
		else
		begin
			pwr_elapsed <= port_power_start ? 32'h0000_0000 : pwr_elapsed + 32'h0000_0001;
			if (port_power_start)
				pwr_snap <= power_on_reg;
			if (take)
			begin
				emitted  <= '0;
				len_snap <= sel_len;
			end
			else if (text_out.valid)
				emitted <= emitted + 6'h01;
		end
	end

	default clocking hdc_cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_current_scale: assert property (
		$past(nrst) |-> hub_ctrl_current_ma == 9'($past(hc_current_reg) * CURRENT_STEP_MA))
		else $error("hub current not in 2 mA steps");
	a_current_reset: assert property (
		!$past(nrst) |-> hc_current_reg == HC_CURRENT_RESET)
		else $error("hub current reset value wrong");
	a_power_delay: assert property (
		$rose(port_power_good) |-> pwr_elapsed == 32'(pwr_snap) * STEP_CYCLES + 1)
		else $error("port power good at wrong time");
	a_power_clear: assert property (
		port_power_start |=> !port_power_good)
		else $error("power good not cleared on start");
	a_lang_join: assert property (
		language_id == {$past(lang_upper_reg), $past(lang_lower_reg)})
		else $error("language id bytes misplaced");
	a_len_limit: assert property (
		maker_len_reg <= MAX_TEXT_CHARS && product_len_reg <= MAX_TEXT_CHARS &&
		serial_len_reg <= MAX_TEXT_CHARS)
		else $error("string length above limit");
	a_len_refused: assert property (
		cfg.wr && cfg.addr == OFF_MAKER_LEN && cfg.wdata > MAX_TEXT_CHARS
		|=> cfg_refused && $stable(maker_len_reg))
		else $error("long length not refused");
	a_char_bytes: assert property (
		text_out.valid |-> text_out.data == $past(pair_now))
		else $error("character byte order wrong");
	a_maker_base: assert property (
		take && text_sel == HDC_SEL_MAKER && maker_len_reg != REG_RESET
		|=> idx_reg == BASE_MAKER)
		else $error("maker region start wrong");
	a_product_base: assert property (
		take && text_sel == HDC_SEL_PRODUCT && product_len_reg != REG_RESET
		|=> idx_reg == BASE_PRODUCT)
		else $error("product region start wrong");
	a_serial_base: assert property (
		take && text_sel == HDC_SEL_SERIAL && serial_len_reg != REG_RESET
		|=> idx_reg == BASE_SERIAL)
		else $error("serial region start wrong");
	a_char_count: assert property (
		text_done |-> 8'(emitted) + 8'(text_out.valid) == len_snap)
		else $error("emitted character count wrong");

	c_maker_fetch:  cover property (take && text_sel == HDC_SEL_MAKER ##[1:40] text_done);
	c_full_string:  cover property (text_done && text_out.valid && len_snap == MAX_TEXT_CHARS);
	c_refused:      cover property (cfg_refused);
	c_power_good:   cover property ($rose(port_power_good));

endmodule // hdc_config_bank

`default_nettype wire

// File: hdc_cfg_source.sv
// Behavioural configuration source that loads the string image at start-up
`timescale 1ns/1ps
`default_nettype none

module hdc_cfg_source
	import hdc_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            nrst,
	output var  hdc_cfg_access_t cfg_o,
	output var  logic            done
);
	// ----------------------------------------------------------------
	// Loader
	// ----------------------------------------------------------------
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		cfg_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
	endtask

	initial
	begin
		cfg_o = '0;
		done  = 1'b0;
		wait (nrst === 1'b1);
		// Byte a holds a^5A, so char k is {byte 2k+1, byte 2k} low first
		for (int a = 8'h16; a <= 8'hCF; a++)
			put(8'(a), 8'(a) ^ 8'h5A);
		put(8'h13, 8'h03);
		put(8'h14, 8'h05);
		put(8'h15, 8'h00);
		@(posedge clk);
		cfg_o <= '0;
		done  <= 1'b1;
	end
endmodule // hdc_cfg_source

`default_nettype wire

// File: hdc_config_bank_tb.sv
// Self-checking testbench for the hub descriptor configuration bank
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_fail++; \
	$display("[ERR] %0t got %h expected %h", $time, got, exp); end end

module hdc_config_bank_tb
	import hdc_pkg::*;
;
	logic            clk = 1'b0;
	logic            nrst = 1'b0;
	hdc_cfg_access_t cfg_tb = '0;
	hdc_cfg_access_t cfg_src;
	hdc_cfg_access_t cfg;
	logic            src_done;
	logic            text_req = 1'b0;
	hdc_text_sel_t   text_sel = HDC_SEL_MAKER;
	logic            port_power_start = 1'b0;
	logic [7:0]      cfg_rdata;
	logic            cfg_rvalid;
	logic            cfg_refused;
	logic [8:0]      hub_ctrl_current_ma;
	logic [15:0]     language_id;
	logic            port_power_good;
	hdc_text_char_t  text_out;
	logic            text_done;
	logic            text_busy;
	int              n_fail = 0;
	int              checked = 0;

	always #4 clk = ~clk;
	assign cfg = src_done ? cfg_tb : cfg_src;

	hdc_cfg_source hdc_cfg_source_i (.clk(clk), .nrst(nrst), .cfg_o(cfg_src), .done(src_done));

	hdc_config_bank #(.STEP_CYCLES(4)) hdc_config_bank_i (
		.clk(clk), .nrst(nrst), .cfg(cfg), .text_req(text_req), .text_sel(text_sel),
		.port_power_start(port_power_start), .cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid), .cfg_refused(cfg_refused),
		.hub_ctrl_current_ma(hub_ctrl_current_ma), .language_id(language_id),
		.port_power_good(port_power_good), .text_out(text_out),
		.text_done(text_done), .text_busy(text_busy));

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic refused);
		@(posedge clk);
		cfg_tb <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		cfg_tb.wr <= 1'b0;
		#1;
		`CHK(cfg_refused, refused)
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		cfg_tb <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		cfg_tb.rd <= 1'b0;
		#1;
		`CHK(cfg_rvalid, 1'b1)
		`CHK(cfg_rdata, exp)
	endtask

	task automatic fetch(input hdc_text_sel_t s, input logic [7:0] base, input int len);
		logic [7:0] a;
		@(posedge clk);
		text_req <= 1'b1;
		text_sel <= s;
		@(posedge clk);
		text_req <= 1'b0;
		// Empty string finishes at the take edge itself
		#1;
		`CHK(text_done, len == 0)
		`CHK(text_out.valid, 1'b0)
		`CHK(text_busy, len > 0)
		for (int k = 0; k < len; k++)
		begin
			@(posedge clk);
			#1;
			a = base + 8'(2 * k);
			`CHK(text_out.valid, 1'b1)
			`CHK(text_out.data, {(a + 8'h01) ^ 8'h5A, a ^ 8'h5A})
			`CHK(text_out.last, k == len - 1)
			`CHK(text_done, k == len - 1)
			`CHK(text_busy, k < len - 1)
		end
		// Nothing may follow the counted characters
		@(posedge clk);
		#1;
		`CHK(text_out.valid, 1'b0)
	endtask

	task automatic power(input logic [7:0] n, input int good_edge);
		wr(8'h10, n, 1'b0);
		@(posedge clk);
		port_power_start <= 1'b1;
		@(posedge clk);
		port_power_start <= 1'b0;
		repeat (good_edge - 1) @(posedge clk);
		#1;
		`CHK(port_power_good, 1'b0)
		@(posedge clk);
		#1;
		`CHK(port_power_good, 1'b1)
	endtask

	task automatic print_verdict();
		if (n_fail == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 1000 && !src_done; i++)
			@(posedge clk);
		`CHK(src_done, 1'b1)
		rd(8'h0F, 8'h32);
		`CHK(hub_ctrl_current_ma, 9'h064)
		wr(8'h0F, 8'h7F, 1'b0);
		@(posedge clk);
		#1;
		`CHK(hub_ctrl_current_ma, 9'h0FE)
		wr(8'h11, 8'h04, 1'b0);
		wr(8'h12, 8'h09, 1'b0);
		@(posedge clk);
		#1;
		`CHK(language_id, 16'h0409)
		rd(8'h13, 8'h03);
		wr(8'h13, 8'h20, 1'b1);
		wr(8'h14, 8'hFF, 1'b1);
		rd(8'h13, 8'h03);
		rd(8'h14, 8'h05);
		wr(8'h13, 8'h1F, 1'b0);
		rd(8'h13, 8'h1F);
		rd(8'hD0, 8'h00);
		rd(8'h53, 8'h53 ^ 8'h5A);
		fetch(HDC_SEL_MAKER, 8'h16, 31);
		fetch(HDC_SEL_PRODUCT, 8'h54, 5);
		fetch(HDC_SEL_SERIAL, 8'h92, 0);
		fetch(hdc_text_sel_t'(2'h3), 8'h00, 0);
		wr(8'h15, 8'h1F, 1'b0);
		fetch(HDC_SEL_SERIAL, 8'h92, 31);
		power(8'h03, 13);
		power(8'h00, 1);
		// Mid-run reset must bring back the default current
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1;
		`CHK(port_power_good, 1'b0)
		rd(8'h0F, 8'h32);
		`CHK(hub_ctrl_current_ma, 9'h064)
		print_verdict();
	end

	initial
	begin
		#200us;
		n_fail++;
		print_verdict();
	end
endmodule // hdc_config_bank_tb

`undef CHK
`default_nettype wire
